// File: amseq_cfg.svh
`ifndef AMSEQ_CFG_SVH
`define AMSEQ_CFG_SVH
// Mode field codes
`define AMSEQ_MODE_IDLE   3'h0
`define AMSEQ_MODE_CONT   3'h1
`define AMSEQ_MODE_SINGLE 3'h2
`define AMSEQ_MODE_STBY   3'h3
`define AMSEQ_MODE_SELFZS 3'h4
`define AMSEQ_MODE_RSVD   3'h5
`define AMSEQ_MODE_SYSZS  3'h6
`define AMSEQ_MODE_SYSFS  3'h7
// Reset values
`define AMSEQ_RST_MODE    3'h0
`define AMSEQ_RST_RDY     4'h0
// Timing: default work length of one calibration, in cycles
`define AMSEQ_CAL_CYCLES  16'h0040
`endif

// File: amseq_pkg.sv
package amseq_pkg;
  typedef logic [2:0] amseq_mode_t;
  typedef logic [1:0] amseq_chan_t;
  typedef enum logic [2:0] {
    AMSEQ_IDLE, AMSEQ_CONV, AMSEQ_CAL, AMSEQ_STBY
  } amseq_state_t;
endpackage : amseq_pkg

// File: amseq_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs, reset to the pins' idle high level
module amseq_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Data
  input  wire logic din,
  output logic      dout
);
  logic stage1;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b1;
      dout   <= 1'b1;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule : amseq_sync

// File: amseq_mode_sequencer.sv
`timescale 1ns/1ps
// Operation
// - Idle, mode zero, after power-on and every reset.
// - Return to idle after any calibration or single conversion.
// - Continuous: convert channel, update data/status, set ready flag, next.
// - Continuous rotation through enabled channels until new mode or reset.
// - Rotation period equals sum of enabled channels' conversion times.
// - Single: convert once, set flag, ready pin low, mode cleared, idle.
// - Single conversion runs even on a disabled channel.
// - Standby powers down converter; serial port stays usable.
// - Clock output disable independent of standby.
// - Self zero-scale cal: update cal, all flags, pin low, idle.
// - System zero-scale cal on channel: update, all flags, pin low, idle.
// - System full-scale cal on channel: update, all flags, pin low, idle.
// - Select high: ignore serial clock and input, serial output released.
// - Ready pin always driven, never high impedance.
// - Hardware reset pin restores default state.
// - Mode write clears status, pin high, aborts, starts new mode.
// - Low two address bits of mode write select the channel.
// - Reading a channel's data clears its flag, pin returns high.
`include "amseq_cfg.svh"
module amseq_mode_sequencer (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 hwReset_n,
  // Mode register write
  input  wire logic                 modeWrite,
  input  wire amseq_pkg::amseq_mode_t modeIn,
  input  wire amseq_pkg::amseq_chan_t chanIn,
  input  wire logic                 clockOutputDisable,
  // Channel configuration
  input  wire logic [3:0]           chanEnable,
  input  wire logic [63:0]          convCycles,
  input  wire logic [3:0]           dataRead,
  // Serial pins
  input  wire logic                 select_n,
  input  wire logic                 serialClk,
  input  wire logic                 serialIn,
  input  wire logic                 serialOutData,
  output logic                      serialOut,
  output logic                      serialOutEn_n,
  output logic                      serialClkGated,
  output logic                      serialInGated,
  // Status and control
  output amseq_pkg::amseq_mode_t    opModeField,
  output logic [3:0]                readyFlags,
  output logic                      ready_n,
  output logic                      converterPowerDown,
  output logic                      masterClockOutEn_n,
  output logic [3:0]                dataUpdate,
  output logic                      selfZeroCalUpdate,
  output logic [3:0]                zeroCalUpdate,
  output logic [3:0]                fullCalUpdate
);
  import amseq_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic selSync_n;
  logic hwRstSync_n;
  logic sclkSync;
  logic sinSync;
  amseq_sync uSel (.clock(clock), .rst_n(rst_n), .din(select_n),
                   .dout(selSync_n));
  amseq_sync uRst (.clock(clock), .rst_n(rst_n), .din(hwReset_n),
                   .dout(hwRstSync_n));
  amseq_sync uClk (.clock(clock), .rst_n(rst_n), .din(serialClk),
                   .dout(sclkSync));
  amseq_sync uDin (.clock(clock), .rst_n(rst_n), .din(serialIn),
                   .dout(sinSync));

  // ==========================================================
  // Helpers
  function automatic logic [15:0] convLen(input logic [63:0] cyc,
                                          input amseq_chan_t ch);
    convLen = cyc[{ch, 4'h0} +: 16];
  endfunction : convLen

  function automatic amseq_chan_t nextChan(input amseq_chan_t ch,
                                           input logic [3:0] en);
    amseq_chan_t c;
    c = ch;
    nextChan = ch;
    for (int i = 1; i <= 4; i++) begin
      c = amseq_chan_t'(ch + i[1:0]);
      if (en[c] && nextChan == ch && i < 4) nextChan = c;
    end
  endfunction : nextChan

  // ==========================================================
  // Sequencer state
  amseq_state_t state;
  amseq_state_t next_state;
  amseq_mode_t  next_opModeField;
  amseq_chan_t  chan;
  amseq_chan_t  next_chan;
  logic [15:0]  count;
  logic [15:0]  next_count;
  logic [3:0]   next_readyFlags;
  logic         next_ready_n;
  logic [3:0]   next_dataUpdate;
  logic         next_selfZeroCalUpdate;
  logic [3:0]   next_zeroCalUpdate;
  logic [3:0]   next_fullCalUpdate;
  logic         hwReset;

  assign hwReset = !hwRstSync_n;

  always_comb begin
    next_state             = state;
    next_opModeField       = opModeField;
    next_chan              = chan;
    next_count             = count;
    next_readyFlags        = readyFlags & ~dataRead;
    next_ready_n           = ready_n | (|dataRead);
    next_dataUpdate        = 4'h0;
    next_selfZeroCalUpdate = 1'b0;
    next_zeroCalUpdate     = 4'h0;
    next_fullCalUpdate     = 4'h0;
    if (hwReset) begin
      next_state       = AMSEQ_IDLE;
      next_opModeField = `AMSEQ_RST_MODE;
      next_readyFlags  = `AMSEQ_RST_RDY;
      next_ready_n     = 1'b1;
      next_count       = 16'h0000;
    end else if (modeWrite) begin
      next_opModeField = modeIn;
      next_chan        = chanIn;
      next_readyFlags  = 4'h0;
      next_ready_n     = 1'b1;
      case (modeIn)
        `AMSEQ_MODE_CONT, `AMSEQ_MODE_SINGLE: begin
          next_state = AMSEQ_CONV;
          next_count = convLen(convCycles, chanIn);
        end
        `AMSEQ_MODE_SELFZS, `AMSEQ_MODE_SYSZS,
        `AMSEQ_MODE_SYSFS: begin
          next_state = AMSEQ_CAL;
          next_count = `AMSEQ_CAL_CYCLES;
        end
        `AMSEQ_MODE_STBY: next_state = AMSEQ_STBY;
        default: next_state = AMSEQ_IDLE;
      endcase
    end else begin
      case (state)
        AMSEQ_CONV: begin
          if (count > 16'h0001) begin
            next_count = count - 16'h0001;
          end else begin
            next_dataUpdate[chan] = 1'b1;
            next_readyFlags[chan] = 1'b1;
            next_ready_n          = 1'b0;
            if (opModeField == `AMSEQ_MODE_SINGLE) begin
              next_state       = AMSEQ_IDLE;
              next_opModeField = `AMSEQ_MODE_IDLE;
            end else begin
              next_chan  = nextChan(chan, chanEnable);
              next_count = convLen(convCycles,
                                   nextChan(chan, chanEnable));
            end
          end
        end
        AMSEQ_CAL: begin
          if (count > 16'h0001) begin
            next_count = count - 16'h0001;
          end else begin
            case (opModeField)
              `AMSEQ_MODE_SELFZS: next_selfZeroCalUpdate = 1'b1;
              `AMSEQ_MODE_SYSZS: next_zeroCalUpdate[chan] = 1'b1;
              default: next_fullCalUpdate[chan] = 1'b1;
            endcase
            next_readyFlags  = 4'hF;
            next_ready_n     = 1'b0;
            next_state       = AMSEQ_IDLE;
            next_opModeField = `AMSEQ_MODE_IDLE;
          end
        end
        AMSEQ_STBY: next_state = AMSEQ_STBY;
        default: next_state = AMSEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state             <= AMSEQ_IDLE;
      opModeField       <= `AMSEQ_RST_MODE;
      chan              <= 2'h0;
      count             <= 16'h0000;
      readyFlags        <= `AMSEQ_RST_RDY;
      ready_n           <= 1'b1;
      dataUpdate        <= 4'h0;
      selfZeroCalUpdate <= 1'b0;
      zeroCalUpdate     <= 4'h0;
      fullCalUpdate     <= 4'h0;
    end else begin
      state             <= next_state;
      opModeField       <= next_opModeField;
      chan              <= next_chan;
      count             <= next_count;
      readyFlags        <= next_readyFlags;
      ready_n           <= next_ready_n;
      dataUpdate        <= next_dataUpdate;
      selfZeroCalUpdate <= next_selfZeroCalUpdate;
      zeroCalUpdate     <= next_zeroCalUpdate;
      fullCalUpdate     <= next_fullCalUpdate;
    end
  end

  // ==========================================================
  // Power, clock output and serial gating
  logic next_serialOut;
  always_comb begin
    next_serialOut = selSync_n ? 1'b0 : serialOutData;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      serialOut <= 1'b0;
    end else begin
      serialOut <= next_serialOut;
    end
  end
  assign converterPowerDown = (state == AMSEQ_STBY);
  assign masterClockOutEn_n = clockOutputDisable;
  assign serialOutEn_n      = selSync_n;
  assign serialClkGated     = sclkSync & !selSync_n;
  assign serialInGated      = sinSync & !selSync_n;

  // ==========================================================
  // Checks
  sequence seqSingleEnd;
    $rose(|dataUpdate) && $past(opModeField) == `AMSEQ_MODE_SINGLE;
  endsequence
  sequence seqCalEnd;
    selfZeroCalUpdate || |zeroCalUpdate || |fullCalUpdate;
  endsequence
  AST_WRITE_CLEARS: assert property (
    @(posedge clock) disable iff (!rst_n)
    modeWrite && !hwReset |=> ready_n && readyFlags == 4'h0)
    else $error("mode write did not clear status");
  AST_RESET_IDLE: assert property (
    @(posedge clock) disable iff (!rst_n)
    hwReset |=> opModeField == 3'h0 && state == AMSEQ_IDLE)
    else $error("reset did not return to idle");
  AST_SINGLE_DONE: assert property (
    @(posedge clock) disable iff (!rst_n)
    seqSingleEnd |-> opModeField == 3'h0 && !ready_n)
    else $error("single conversion did not end in idle");
  AST_CAL_ALLFLAGS: assert property (
    @(posedge clock) disable iff (!rst_n)
    seqCalEnd |-> readyFlags == 4'hF && !ready_n && state == AMSEQ_IDLE)
    else $error("calibration end flags wrong");
  AST_STBY_PD: assert property (
    @(posedge clock) disable iff (!rst_n)
    opModeField == 3'h3 |-> converterPowerDown)
    else $error("standby without power down");
  AST_RSVD_IDLE: assert property (
    @(posedge clock) disable iff (!rst_n)
    modeWrite && !hwReset && modeIn == 3'h5 |=> state == AMSEQ_IDLE)
    else $error("reserved mode started work");
  AST_CONT_STAYS: assert property (
    @(posedge clock) disable iff (!rst_n)
    |dataUpdate && opModeField == 3'h1 |-> state == AMSEQ_CONV)
    else $error("continuous mode stopped");
  AST_READ_CLEARS: assert property (
    @(posedge clock) disable iff (!rst_n)
    dataRead[0] && !modeWrite && !hwReset && state == AMSEQ_IDLE
      |=> !readyFlags[0] && ready_n)
    else $error("data read did not clear flag");
endmodule : amseq_mode_sequencer

// File: amseq_host_model.sv
`timescale 1ns/1ps
// ========================================
// Host side of the serial port
module amseq_host_model (
  // Pins
  input  wire logic readyPin,
  output logic      select_n,
  output logic      serialClk,
  output logic      serialIn
);
  int readyFalls;
  initial begin
    select_n = 1'b1;
    serialClk = 1'b1;
    serialIn = 1'b1;
    readyFalls = 0;
  end
  // Completion seen on a falling ready pin
  always @(negedge readyPin) readyFalls++;
  // One byte; selLow low sends it with the device left unselected
  task automatic frame(input logic [7:0] b, input logic selLow);
    select_n = ~selLow;
    for (int i = 7; i >= 0; i--) begin
      serialIn = b[i];
      #62.5 serialClk = 1'b0;
      #62.5 serialClk = 1'b1;
    end
    select_n = 1'b1;
    serialIn = ~b[0];
  endtask : frame
endmodule : amseq_host_model

// File: amseq_mode_sequencer_test.sv
`timescale 1ns/1ps
`include "amseq_cfg.svh"
// ========================================
// Bench for the mode sequencer
module amseq_mode_sequencer_test;
  import amseq_pkg::*;
  typedef struct {
    amseq_mode_t m; amseq_chan_t c; int n; logic [3:0] f; logic [12:0] u;
  } amseq_row_t;
  logic clock = 1'b0, rst_n = 1'b0, hwReset_n = 1'b1, modeWrite = 1'b0;
  amseq_mode_t modeIn = 3'h0, opModeField;
  amseq_chan_t chanIn = 2'h0;
  logic clockOutputDisable = 1'b0, serialOutData = 1'b1;
  logic [3:0] chanEnable = 4'h5, dataRead = 4'h0;
  logic [63:0] convCycles = 64'h0004_0002_0009_0003;
  logic select_n, serialClk, serialIn, serialOut, serialOutEn_n;
  logic serialClkGated, serialInGated, ready_n, converterPowerDown;
  logic masterClockOutEn_n, selfZeroCalUpdate;
  logic [3:0] readyFlags, dataUpdate, zeroCalUpdate, fullCalUpdate;
  wire [12:0] upd = {dataUpdate, selfZeroCalUpdate, zeroCalUpdate,
                     fullCalUpdate};
  int n_fail = 0, compares = 0, cycles = 0, cnt;
  logic [2:0] seen;
  localparam int CAL = int'(`AMSEQ_CAL_CYCLES);
  amseq_row_t rows[5] = '{
    '{`AMSEQ_MODE_SINGLE, 2'h1, 9, 4'h2, 13'h0400},
    '{`AMSEQ_MODE_SINGLE, 2'h3, 4, 4'h8, 13'h1000},
    '{`AMSEQ_MODE_SELFZS, 2'h0, CAL, 4'hF, 13'h0100},
    '{`AMSEQ_MODE_SYSZS, 2'h2, CAL, 4'hF, 13'h0040},
    '{`AMSEQ_MODE_SYSFS, 2'h3, CAL, 4'hF, 13'h0008}};
  always #5 clock = ~clock;
  amseq_mode_sequencer i_amseq_mode_sequencer (.clock, .rst_n, .hwReset_n,
    .modeWrite, .modeIn, .chanIn, .clockOutputDisable, .chanEnable,
    .convCycles, .dataRead, .select_n, .serialClk, .serialIn,
    .serialOutData, .serialOut, .serialOutEn_n, .serialClkGated,
    .serialInGated, .opModeField, .readyFlags, .ready_n,
    .converterPowerDown, .masterClockOutEn_n, .dataUpdate,
    .selfZeroCalUpdate, .zeroCalUpdate, .fullCalUpdate);
  amseq_host_model i_amseq_host_model (.readyPin(ready_n), .select_n,
    .serialClk, .serialIn);
  // ========================================
  // Tasks
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input amseq_mode_t m, input amseq_chan_t c);
    @(posedge clock);
    modeWrite <= 1'b1;
    modeIn <= m;
    chanIn <= c;
    @(posedge clock);
    modeWrite <= 1'b0;
  endtask : wr
  task automatic waitEv(input int lim, output int n);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (upd === 13'h0000 && n < lim);
  endtask : waitEv
  task automatic close_out;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      close_out();
    end
  end
  // ========================================
  // Sequence
  initial begin
    repeat (20) @(posedge clock);
    @(negedge clock);
    chk(16'({opModeField, readyFlags, ready_n}), 16'h0001);
    @(posedge clock);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].m, rows[i].c);
      @(negedge clock);
      chk(16'({opModeField, ready_n}), 16'({rows[i].m, 1'b1}));
      waitEv(200, cnt);
      chk(16'(cnt), 16'(rows[i].n));
      chk({3'h0, upd}, {3'h0, rows[i].u});
      chk(16'(readyFlags), 16'(rows[i].f));
      chk(16'({ready_n, opModeField}), 16'h0000);
      @(posedge clock);
      dataRead <= rows[i].f;
      @(posedge clock);
      dataRead <= 4'h0;
      @(negedge clock);
      chk(16'({readyFlags, ready_n}), 16'h0001);
    end
    $display("test rows done");
    wr(`AMSEQ_MODE_CONT, 2'h0);
    waitEv(200, cnt);
    chk(16'(cnt), 16'h0004);
    chk({3'h0, upd}, 16'h0200);
    waitEv(200, cnt);
    chk(16'(cnt), 16'h0002);
    chk({3'h0, upd}, 16'h0800);
    waitEv(200, cnt);
    chk(16'(cnt), 16'h0003);
    chk(16'({readyFlags, opModeField}), 16'h0029);
    chk(16'(i_amseq_host_model.readyFalls), 16'h0006);
    wr(`AMSEQ_MODE_STBY, 2'h0);
    @(negedge clock);
    chk(16'({readyFlags, ready_n}), 16'h0001);
    chk(16'({opModeField, converterPowerDown}), 16'h0007);
    chk(16'(masterClockOutEn_n), 16'h0000);
    @(posedge clock);
    clockOutputDisable <= 1'b1;
    @(negedge clock);
    chk(16'(masterClockOutEn_n), 16'h0001);
    chk(16'(converterPowerDown), 16'h0001);
    waitEv(20, cnt);
    chk(16'(cnt), 16'h0014);
    $display("test continuous and standby done");
    wr(`AMSEQ_MODE_RSVD, 2'h1);
    waitEv(20, cnt);
    chk(16'(cnt), 16'h0014);
    chk(16'(converterPowerDown), 16'h0000);
    wr(`AMSEQ_MODE_SINGLE, 2'h1);
    hwReset_n <= 1'b0;
    repeat (4) @(posedge clock);
    hwReset_n <= 1'b1;
    waitEv(20, cnt);
    chk(16'(cnt), 16'h0014);
    chk(16'({opModeField, ready_n}), 16'h0001);
    wr(`AMSEQ_MODE_CONT, 2'h2);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    chk(16'({opModeField, readyFlags, ready_n}), 16'h0001);
    $display("test reserved and resets done");
    seen = 3'b000;
    fork
      i_amseq_host_model.frame(8'hA5, 1'b0);
      repeat (110) begin
        @(negedge clock);
        seen |= {serialClkGated, serialInGated, ~serialOutEn_n};
      end
    join
    chk(16'({seen, serialOutEn_n}), 16'h0001);
    seen = 3'b000;
    fork
      i_amseq_host_model.frame(8'h5A, 1'b1);
      repeat (110) begin
        @(negedge clock);
        seen |= {serialClkGated, serialInGated, ~serialOutEn_n & serialOut};
      end
    join
    repeat (4) @(negedge clock);
    chk(16'({seen, serialOutEn_n, serialOut}), 16'h001E);
    $display("test serial select done");
    close_out();
  end
endmodule : amseq_mode_sequencer_test
